// *** logic/gpio_port_control.sv ***
// GPIO port control: five ports, per-pin drive mode, buffers, routing,
// lookup-table fabric, pin state sampling and per-port interrupts.
// Assumes pad inputs synchronous to clock and a one-cycle register port.
`timescale 1ns/1ps
`include "gpc_cfg.svh"
module gpio_port_control (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register port
  input wire logic [`GPC_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  // Peripheral side of the routing multiplexer
  input wire logic [2:0][`GPC_ALL_PINS-1:0] periphOut,
  output logic [`GPC_ALL_PINS-1:0] periphIn,
  // Pad inputs, one per threshold comparator
  input wire logic [`GPC_ALL_PINS-1:0] pinInCmos,
  input wire logic [`GPC_ALL_PINS-1:0] pinInLvttl,
  // Pad controls
  output logic [`GPC_ALL_PINS-1:0] padOut,
  output logic [`GPC_ALL_PINS-1:0] padOe,
  output logic [`GPC_ALL_PINS-1:0] padPullUp,
  output logic [`GPC_ALL_PINS-1:0] padPullDown,
  output logic [`GPC_ALL_PINS-1:0] padInEn,
  output logic [`GPC_ALL_PINS-1:0] padLvttl,
  output logic [`GPC_ALL_PINS-1:0] padSlowSlew,
  // Interrupts
  output logic [`GPC_PORTS-1:0] portIrq,
  output logic irq
);

  localparam logic [`GPC_ALL_PINS-1:0] ImplMask = `GPC_IMPL_MASK;

  // Register storage, one entry per port
  logic [7:0] dout [`GPC_PORTS];
  logic [23:0] mode [`GPC_PORTS];
  logic [15:0] bufEn [`GPC_PORTS];
  logic [15:0] padCfg [`GPC_PORTS];
  logic [15:0] route [`GPC_PORTS];
  logic [7:0] intEn [`GPC_PORTS];
  logic [7:0] intStat [`GPC_PORTS];
  logic [7:0] intMask [`GPC_PORTS];
  logic [31:0] lutCfg [`GPC_PORTS];
  logic [7:0] pinState [`GPC_PORTS];
  logic [7:0] prevState [`GPC_PORTS];
  logic [31:0] rdData;

  logic [7:0] next_dout [`GPC_PORTS];
  logic [23:0] next_mode [`GPC_PORTS];
  logic [15:0] next_bufEn [`GPC_PORTS];
  logic [15:0] next_padCfg [`GPC_PORTS];
  logic [15:0] next_route [`GPC_PORTS];
  logic [7:0] next_intEn [`GPC_PORTS];
  logic [7:0] next_intStat [`GPC_PORTS];
  logic [7:0] next_intMask [`GPC_PORTS];
  logic [31:0] next_lutCfg [`GPC_PORTS];
  logic [7:0] next_pinState [`GPC_PORTS];
  logic [7:0] next_prevState [`GPC_PORTS];
  logic [31:0] next_rdData;

  // Per-pin input level after threshold, gating and fabric
  logic [`GPC_ALL_PINS-1:0] inLevel;

  logic [2:0] portSel;
  logic [5:0] offset;
  assign portSel = regAddr[`GPC_ADDR_W-1:`GPC_PORT_LSB];
  assign offset = regAddr[`GPC_PORT_LSB-1:0];

  // Per-port datapath and per-pin pad control
  genvar p, i;
  for (p = 0; p < `GPC_PORTS; p++) begin : g_port
    gpc_lut_if lutIf ();

    gpc_lut_fabric u_fabric (
      .lut(lutIf.fabric)
    );

    assign lutIf.cfg = lutCfg[p];

    for (i = 0; i < `GPC_PINS; i++) begin : g_pin
      localparam int K = p * `GPC_PINS + i;
      gpc_pkg::gpc_drive_t dm;
      gpc_pkg::gpc_route_t src;
      logic live;
      logic srcData;
      logic data;
      logic outOn;

      assign dm = gpc_pkg::gpc_drive_t'(mode[p][3*i +: 3]);
      assign src = gpc_pkg::gpc_route_t'(route[p][2*i +: 2]);
      // Analog mode or a missing pin keeps both buffers off
      assign live = ImplMask[K] && (dm != gpc_pkg::GPC_DM_ANALOG);

      // Routing multiplexer on the outgoing side
      always_comb begin
        if (src == gpc_pkg::GPC_SRC_PORT) begin
          srcData = dout[p][i];
        end else begin
          srcData = periphOut[2'(src) - 2'h1][K];
        end
      end
      assign lutIf.drvIn[i] = srcData;
      assign data = lutIf.fabOut[i];
      assign outOn = live && bufEn[p][`GPC_HI_HALF + i];

      // Drive mode decode into strong drive and weak pulls
      always_comb begin
        padOe[K] = 1'b0;
        padPullUp[K] = 1'b0;
        padPullDown[K] = 1'b0;
        if (outOn) begin
          unique case (dm)
            gpc_pkg::GPC_DM_ANALOG, gpc_pkg::GPC_DM_INPUT: begin
              padOe[K] = 1'b0;
            end
            gpc_pkg::GPC_DM_WPU_SPD: begin
              padOe[K] = !data;
              padPullUp[K] = data;
            end
            gpc_pkg::GPC_DM_SPU_WPD: begin
              padOe[K] = data;
              padPullDown[K] = !data;
            end
            gpc_pkg::GPC_DM_OD_LOW: begin
              padOe[K] = !data;
            end
            gpc_pkg::GPC_DM_OD_HIGH: begin
              padOe[K] = data;
            end
            gpc_pkg::GPC_DM_STRONG: begin
              padOe[K] = 1'b1;
            end
            gpc_pkg::GPC_DM_WEAK: begin
              padPullUp[K] = data;
              padPullDown[K] = !data;
            end
          endcase
        end
      end
      assign padOut[K] = outOn && data;
      assign padInEn[K] = live && bufEn[p][i];
      assign padLvttl[K] = ImplMask[K] && padCfg[p][i];
      assign padSlowSlew[K] = ImplMask[K] && padCfg[p][`GPC_HI_HALF + i];

      // Incoming side: threshold select, buffer gate, fabric, routing
      assign lutIf.rawIn[i] = padInEn[K] &&
        (padCfg[p][i] ? pinInLvttl[K] : pinInCmos[K]);
      assign inLevel[K] = lutIf.fabIn[i];
      // A missing pin never reaches a peripheral, even through the fabric
      assign periphIn[K] = ImplMask[K] && (src != gpc_pkg::GPC_SRC_PORT) && inLevel[K];
    end

    // One request line per port while an enabled event is pending
    assign portIrq[p] = |(intStat[p] & intMask[p]);
  end

  assign irq = |portIrq;
  assign regRdData = rdData;

  // Register writes, sampling, event capture and read data
  always_comb begin
    logic [7:0] wb;
    logic [7:0] im;
    logic [7:0] ev;
    logic hit;
    wb = 8'h00;
    im = 8'h00;
    ev = 8'h00;
    hit = 1'b0;
    next_rdData = `GPC_RST_WORD;
    for (int n = 0; n < `GPC_PORTS; n++) begin
      im = ImplMask[n*`GPC_PINS +: `GPC_PINS];
      hit = regWrEn && (portSel == 3'(n));
      wb = regWrData[7:0] & im;
      next_dout[n] = dout[n];
      next_mode[n] = mode[n];
      next_bufEn[n] = bufEn[n];
      next_padCfg[n] = padCfg[n];
      next_route[n] = route[n];
      next_intEn[n] = intEn[n];
      next_intMask[n] = intMask[n];
      next_lutCfg[n] = lutCfg[n];
      next_pinState[n] = inLevel[n*`GPC_PINS +: `GPC_PINS] & im;
      next_prevState[n] = pinState[n];
      // Either edge of an enabled pin is an event
      ev = (pinState[n] ^ prevState[n]) & intEn[n];
      next_intStat[n] = intStat[n];
      if (hit && offset == `GPC_OFF_INTSTAT) begin
        next_intStat[n] = intStat[n] & ~regWrData[7:0];
      end
      next_intStat[n] = next_intStat[n] | ev;
      if (hit) begin
        unique case (offset)
          `GPC_OFF_DOUT: next_dout[n] = wb;
          `GPC_OFF_MODE: next_mode[n] = regWrData[23:0];
          `GPC_OFF_BUFEN: next_bufEn[n] = {regWrData[15:8] & im, wb};
          `GPC_OFF_PADCFG: next_padCfg[n] = {regWrData[15:8] & im, wb};
          `GPC_OFF_ROUTE: next_route[n] = regWrData[15:0];
          `GPC_OFF_INTEN: next_intEn[n] = wb;
          `GPC_OFF_INTMASK: next_intMask[n] = wb;
          `GPC_OFF_LUTCFG: next_lutCfg[n] = regWrData;
          default: next_dout[n] = dout[n];
        endcase
      end
      if (regRdEn && portSel == 3'(n)) begin
        unique case (offset)
          `GPC_OFF_DOUT: next_rdData = {24'h000000, dout[n]};
          `GPC_OFF_PSTATE: next_rdData = {24'h000000, pinState[n]};
          `GPC_OFF_MODE: next_rdData = {8'h00, mode[n]};
          `GPC_OFF_BUFEN: next_rdData = {16'h0000, bufEn[n]};
          `GPC_OFF_PADCFG: next_rdData = {16'h0000, padCfg[n]};
          `GPC_OFF_ROUTE: next_rdData = {16'h0000, route[n]};
          `GPC_OFF_INTEN: next_rdData = {24'h000000, intEn[n]};
          `GPC_OFF_INTSTAT: next_rdData = {24'h000000, intStat[n]};
          `GPC_OFF_INTMASK: next_rdData = {24'h000000, intMask[n]};
          `GPC_OFF_LUTCFG: next_rdData = lutCfg[n];
          default: next_rdData = `GPC_RST_WORD;
        endcase
      end
    end
  end

  // State registers; reset leaves every pin analog with buffers off
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int n = 0; n < `GPC_PORTS; n++) begin
        dout[n] <= `GPC_RST_BYTE;
        mode[n] <= `GPC_RST_MODE;
        bufEn[n] <= `GPC_RST_HALF;
        padCfg[n] <= `GPC_RST_HALF;
        route[n] <= `GPC_RST_HALF;
        intEn[n] <= `GPC_RST_BYTE;
        intStat[n] <= `GPC_RST_BYTE;
        intMask[n] <= `GPC_RST_BYTE;
        lutCfg[n] <= `GPC_RST_WORD;
        pinState[n] <= `GPC_RST_BYTE;
        prevState[n] <= `GPC_RST_BYTE;
      end
      rdData <= `GPC_RST_WORD;
    end else begin
      for (int n = 0; n < `GPC_PORTS; n++) begin
        dout[n] <= next_dout[n];
        mode[n] <= next_mode[n];
        bufEn[n] <= next_bufEn[n];
        padCfg[n] <= next_padCfg[n];
        route[n] <= next_route[n];
        intEn[n] <= next_intEn[n];
        intStat[n] <= next_intStat[n];
        intMask[n] <= next_intMask[n];
        lutCfg[n] <= next_lutCfg[n];
        pinState[n] <= next_pinState[n];
        prevState[n] <= next_prevState[n];
      end
      rdData <= next_rdData;
    end
  end

endmodule

// *** inc/gpc_cfg.svh ***
// Constants of the GPIO port block: geometry, register offsets, reset values.
// Assumes a byte-addressed register port, one 32-bit word per register.
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

// Geometry: five ports of up to eight pins each, 32 pins implemented
`define GPC_PORTS 5
`define GPC_PINS 8
`define GPC_ALL_PINS 40
`define GPC_IMPL_MASK 40'hff0f0fffff
`define GPC_ADDR_W 9

// Port register window: port index in address[8:6], word offset in [5:0]
`define GPC_PORT_LSB 6
`define GPC_OFF_DOUT 6'h00
`define GPC_OFF_PSTATE 6'h04
`define GPC_OFF_MODE 6'h08
`define GPC_OFF_BUFEN 6'h0c
`define GPC_OFF_PADCFG 6'h10
`define GPC_OFF_ROUTE 6'h14
`define GPC_OFF_INTEN 6'h18
`define GPC_OFF_INTSTAT 6'h1c
`define GPC_OFF_INTMASK 6'h20
`define GPC_OFF_LUTCFG 6'h24

// Field layout: buffer and pad registers hold input half low, output half high
`define GPC_HI_HALF 8
`define GPC_LUT_IN_TT 16
`define GPC_LUT_OUT_TT 20

// Reset values: everything disabled, analog mode, port register routing
`define GPC_RST_BYTE 8'h00
`define GPC_RST_HALF 16'h0000
`define GPC_RST_MODE 24'h000000
`define GPC_RST_WORD 32'h00000000

`endif

// *** inc/gpc_pkg.sv ***
// Types of the GPIO port block.
// Assumes gpc_cfg.svh for the numeric constants.
package gpc_pkg;

  // Drive configurations of one pin
  typedef enum logic [2:0] {
    GPC_DM_ANALOG = 3'h0,
    GPC_DM_INPUT = 3'h1,
    GPC_DM_WPU_SPD = 3'h2,
    GPC_DM_SPU_WPD = 3'h3,
    GPC_DM_OD_LOW = 3'h4,
    GPC_DM_OD_HIGH = 3'h5,
    GPC_DM_STRONG = 3'h6,
    GPC_DM_WEAK = 3'h7
  } gpc_drive_t;

  // Source of a pin: port data register or one of three peripherals
  typedef enum logic [1:0] {
    GPC_SRC_PORT = 2'h0,
    GPC_SRC_PERIPH0 = 2'h1,
    GPC_SRC_PERIPH1 = 2'h2,
    GPC_SRC_PERIPH2 = 2'h3
  } gpc_route_t;

endpackage

// *** inc/gpc_lut_if.sv ***
// Carrier between the port logic and one port's lookup-table fabric.
// Assumes eight pins per port.
`timescale 1ns/1ps
interface gpc_lut_if;
  logic [31:0] cfg;
  logic [7:0] rawIn;
  logic [7:0] fabIn;
  logic [7:0] drvIn;
  logic [7:0] fabOut;

  modport fabric (
    input cfg,
    input rawIn,
    input drvIn,
    output fabIn,
    output fabOut
  );

  modport port (
    output cfg,
    output rawIn,
    output drvIn,
    input fabIn,
    input fabOut
  );
endinterface

// *** logic/gpc_lut_fabric.sv ***
// Lookup-table fabric of one port, sitting between routing and pins.
// Assumes the configuration word of the port's lookup-table register.
`timescale 1ns/1ps
`include "gpc_cfg.svh"
module gpc_lut_fabric (
  // Port side
  gpc_lut_if.fabric lut
);

  // Each pin: two-input function of its own signal and its upper neighbour, pin 7 wrapping to pin 0
  genvar i;
  for (i = 0; i < `GPC_PINS; i++) begin : g_pin
    localparam int Nb = (i + 1) % `GPC_PINS;
    logic [1:0] inIdx;
    logic [1:0] outIdx;
    assign inIdx = {lut.rawIn[Nb], lut.rawIn[i]};
    assign outIdx = {lut.drvIn[Nb], lut.drvIn[i]};
    assign lut.fabIn[i] = lut.cfg[i] ? lut.cfg[`GPC_LUT_IN_TT + inIdx] :
      lut.rawIn[i];
    assign lut.fabOut[i] = lut.cfg[`GPC_HI_HALF + i] ?
      lut.cfg[`GPC_LUT_OUT_TT + outIdx] : lut.drvIn[i];
  end

endmodule

// *** tb/gpc_assertions.sv ***
// Checker of port-level relations of the GPIO port block.
// Assumes it is bound to gpio_port_control and sees only its ports.
`timescale 1ns/1ps
`include "gpc_cfg.svh"
module gpc_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register port
  input wire logic [`GPC_ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [31:0] regRdData,
  // Pads and requests
  input wire logic [`GPC_ALL_PINS-1:0] periphIn,
  input wire logic [`GPC_ALL_PINS-1:0] padOut,
  input wire logic [`GPC_ALL_PINS-1:0] padOe,
  input wire logic [`GPC_ALL_PINS-1:0] padPullUp,
  input wire logic [`GPC_ALL_PINS-1:0] padPullDown,
  input wire logic [`GPC_ALL_PINS-1:0] padInEn,
  input wire logic [`GPC_ALL_PINS-1:0] padLvttl,
  input wire logic [`GPC_ALL_PINS-1:0] padSlowSlew,
  input wire logic [`GPC_PORTS-1:0] portIrq,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Combined request follows the port requests
  property p_irq; irq == (|portIrq); endproperty
  a_irq: assert property (p_irq) else $error("irq differs from port requests");
  // Read data shows only in the cycle after a read strobe
  property p_rd; regRdData != 32'h0 |-> $past(regRdEn); endproperty
  a_rd: assert property (p_rd) else $error("read data without read");
  // Missing pins stay quiet
  property p_miss; ((padOe | padOut | periphIn | padInEn) & ~`GPC_IMPL_MASK) == 40'h0;
  endproperty
  a_miss: assert property (p_miss) else $error("missing pin active");
  // Pulls never fight the strong driver or each other
  property p_off;
    ((padOe & (padPullUp | padPullDown)) | (padPullUp & padPullDown)) == 40'h0;
  endproperty
  a_off: assert property (p_off) else $error("pull fights driver");
  // Ports beyond the fifth read zero
  property p_port; regRdEn && regAddr[8:6] > 3'h4 |=> regRdData == 32'h0; endproperty
  a_port: assert property (p_port) else $error("absent port read nonzero");
  // Threshold and slew selects move only after a write
  property p_pad; !$stable(padLvttl) || !$stable(padSlowSlew) |-> $past(regWrEn);
  endproperty
  a_pad: assert property (p_pad) else $error("pad select moved unwritten");
  // A request drops only after a write
  property p_hold; (~portIrq & $past(portIrq)) != 5'h0 |-> $past(regWrEn); endproperty
  a_hold: assert property (p_hold) else $error("request dropped unwritten");
  // Input enables move only after a write
  property p_inen; !$stable(padInEn) |-> $past(regWrEn, 1); endproperty
  a_inen: assert property (p_inen) else $error("input enable moved unwritten");
endmodule
bind gpio_port_control gpc_assertions u_chk (.clock(clock), .arst_n(arst_n),
  .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .periphIn(periphIn), .padOut(padOut), .padOe(padOe), .padInEn(padInEn),
  .padPullUp(padPullUp), .padPullDown(padPullDown),
  .padLvttl(padLvttl), .padSlowSlew(padSlowSlew), .portIrq(portIrq), .irq(irq));

// *** tb/gpc_board.sv ***
// Board model: pin wires and the two threshold comparators.
// Assumes strong drivers win over the weak board drive.
`timescale 1ns/1ps
module gpc_board (
  // Clock
  input wire logic clock,
  // Pad controls
  input wire logic [39:0] padOut,
  input wire logic [39:0] padOe,
  input wire logic [39:0] padPullUp,
  input wire logic [39:0] padPullDown,
  // Board drive
  input wire logic [39:0] extEn,
  input wire logic [39:0] extVal,
  input wire logic [39:0] midLvl,
  // Comparators
  output logic [39:0] pinInCmos,
  output logic [39:0] pinInLvttl
);
  logic [39:0] level;
  logic [39:0] floatPat = 40'h0;
  // Floating pins wander every cycle
  always @(posedge clock) floatPat <= ~floatPat;
  // Driver, then board, then pulls; a mid level splits the thresholds
  always_comb begin
    level = (padOe & padOut) | (~padOe & extEn & extVal);
    level = level | (~padOe & ~extEn & (padPullUp | (~padPullDown & floatPat)));
    pinInCmos = level & ~midLvl;
    pinInLvttl = level | midLvl;
  end
endmodule

// *** tb/gpio_port_control_bench.sv ***
// Self-checking bench of the GPIO port block.
// Assumes the board model on the pads and a one-cycle register port.
`timescale 1ns/1ps
module gpio_port_control_bench;
  logic clock, arst_n, regWrEn, regRdEn, irq;
  logic [8:0] regAddr;
  logic [31:0] regWrData, regRdData, d;
  logic [2:0][39:0] periphOut;
  logic [39:0] periphIn, pinInCmos, pinInLvttl, padOut, padOe, padPullUp, padPullDown;
  logic [39:0] padInEn, padLvttl, padSlowSlew, extEn, extVal, midLvl;
  logic [4:0] portIrq;
  logic [6:0] r;
  int fail_count = 0;
  int compares = 0;
  // Rows: pad data, mode, register data, strong drive, pin state
  localparam logic [6:0] ROWS [16] = '{7'h00, 7'h04, 7'h09, 7'h4d, 7'h12, 7'h55, 7'h19,
    7'h5f, 7'h22, 7'h65, 7'h29, 7'h6f, 7'h32, 7'h77, 7'h39, 7'h7d};
  gpio_port_control u_dut (.clock(clock), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .periphOut(periphOut), .periphIn(periphIn), .pinInCmos(pinInCmos),
    .pinInLvttl(pinInLvttl), .padOut(padOut), .padOe(padOe), .padPullUp(padPullUp),
    .padPullDown(padPullDown), .padInEn(padInEn), .padLvttl(padLvttl),
    .padSlowSlew(padSlowSlew), .portIrq(portIrq), .irq(irq));
  gpc_board u_board (.clock(clock), .padOut(padOut), .padOe(padOe),
    .padPullUp(padPullUp), .padPullDown(padPullDown), .extEn(extEn), .extVal(extVal),
    .midLvl(midLvl), .pinInCmos(pinInCmos), .pinInLvttl(pinInLvttl));
  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Compare and count
  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One write cycle, then let outputs settle
  task automatic wr(input logic [8:0] a, input logic [31:0] v);
    @(posedge clock);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    @(posedge clock);
    regWrEn <= 1'b0;
    #1;
  endtask
  // One read cycle, data taken in the cycle after
  task automatic rd(input logic [8:0] a, output logic [31:0] v);
    @(posedge clock);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clock);
    regRdEn <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {regAddr, regWrData, regWrEn, regRdEn, periphOut, midLvl} = '0;
    extEn = 40'h0000000101;
    extVal = 40'h0000000101;
    arst_n = 1'b0;
    tick(5);
    chk("padOe", 40'h0, padOe);
    chk("padInEn", 40'h0, padInEn);
    @(posedge clock) arst_n <= 1'b1;
    wr(9'h00c, 32'h0101);
    for (int i = 0; i < 16; i++) begin
      r = ROWS[i];
      wr(9'h000, {31'h0, r[2]});
      wr(9'h008, {29'h0, r[5:3]});
      rd(9'h004, d);
      chk("padOe", r[1], padOe[0]);
      chk("padOut", r[6], padOut[0]);
      chk("pstate", r[0], d[0]);
    end
    chk("padPullUp", 40'h1, padPullUp);
    chk("padPullDown", 40'h0, padPullDown);
    $display("Done: drive modes");
    wr(9'h008, 32'h6);
    wr(9'h00c, 32'h0001);
    chk("padOe", 40'h0, padOe[0]);
    wr(9'h00c, 32'h0100);
    rd(9'h004, d);
    chk("pstate", 40'h0, d[0]);
    chk("padInEn", 40'h0, padInEn[0]);
    wr(9'h00c, 32'h0101);
    wr(9'h008, 32'h1);
    @(posedge clock) midLvl <= 40'h1;
    rd(9'h004, d);
    chk("pstate cmos", 40'h0, d[0]);
    wr(9'h010, 32'h0101);
    rd(9'h004, d);
    chk("pstate lvttl", 40'h1, d[0]);
    chk("padLvttl", 40'h1, padLvttl);
    chk("padSlowSlew", 40'h1, padSlowSlew);
    @(posedge clock) midLvl <= 40'h0;
    $display("Done: buffers and thresholds");
    wr(9'h008, 32'h6);
    wr(9'h014, 32'h1);
    chk("padOut routed", 40'h0, padOut[0]);
    @(posedge clock) periphOut[0][0] <= 1'b1;
    tick(1);
    chk("padOut routed", 40'h1, padOut[0]);
    chk("periphIn", 40'h1, periphIn[0]);
    wr(9'h014, 32'h0);
    wr(9'h024, 32'h00600100);
    chk("lut out", 40'h1, padOut[0]);
    wr(9'h000, 32'h3);
    chk("lut out", 40'h0, padOut[0]);
    wr(9'h024, 32'h0);
    $display("Done: routing and lookup table");
    wr(9'h008, 32'h1);
    wr(9'h018, 32'h1);
    wr(9'h020, 32'h1);
    wr(9'h048, 32'h1);
    wr(9'h04c, 32'h1);
    wr(9'h060, 32'h1);
    @(posedge clock) extVal <= 40'h0;
    tick(1);
    chk("portIrq early", 40'h0, portIrq);
    tick(1);
    chk("portIrq", 40'h1, portIrq);
    chk("irq", 40'h1, irq);
    wr(9'h020, 32'h0);
    chk("irq masked", 40'h0, irq);
    rd(9'h01c, d);
    chk("intstat", 40'h1, d);
    wr(9'h020, 32'h1);
    chk("irq unmasked", 40'h1, irq);
    wr(9'h01c, 32'h1);
    chk("irq cleared", 40'h0, irq);
    $display("Done: interrupts");
    wr(9'h080, 32'hff);
    rd(9'h080, d);
    chk("short port", 40'h0f, d);
    wr(9'h140, 32'hff);
    rd(9'h140, d);
    chk("absent port", 40'h0, d);
    rd(9'h028, d);
    chk("unmapped", 40'h0, d);
    @(posedge clock) arst_n <= 1'b0;
    tick(2);
    chk("padOe reset", 40'h0, padOe);
    chk("irq reset", 40'h0, irq);
    @(posedge clock) arst_n <= 1'b1;
    rd(9'h000, d);
    chk("dout reset", 40'h0, d);
    $display("Done: geometry and reset");
    close_out();
  end
endmodule
